// File: src/rbs_pkg.sv
// package for the reset and brown-out sequencer: register map, fields, modes, timing
// assumes a single 250 MHz clock domain and a plain strobe register port
package rbs_pkg;

  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [3:0] RBS_BROWNOUT_CONTROL_ADDR = 4'h0;
  localparam int RBS_SW_EN_BIT = 7;
  localparam int RBS_FAST_START_BIT = 6;
  localparam int RBS_READY_BIT = 0;
  localparam logic RBS_SW_EN_RST = 1'b1;
  localparam logic RBS_FAST_START_RST = 1'b0;

  // ----------------------------------------
  // brown-out modes
  // ----------------------------------------
  localparam logic [1:0] RBS_MODE_OFF = 2'h0;
  localparam logic [1:0] RBS_MODE_SW = 2'h1;
  localparam logic [1:0] RBS_MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] RBS_MODE_ON = 2'h3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int RBS_CLK_MHZ = 250;
  localparam int RBS_PUT_MS = 64;
  localparam int RBS_LFO_HZ = 31000;
  // low-frequency tick divider from the main clock, rounded down
  localparam int RBS_LFO_DIV = (RBS_CLK_MHZ * 1000000) / RBS_LFO_HZ;
  // power-up timer terminal count in low-frequency ticks, rounded up
  localparam int RBS_PUT_TICKS = (RBS_PUT_MS * RBS_LFO_HZ + 999) / 1000;
  localparam int RBS_START_CYC = 10;
  localparam int RBS_FILTER_NS = 1000;
  localparam int RBS_FILTER_CYC = (RBS_FILTER_NS * RBS_CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RBS_ST_HOLD = 2'b00,
    RBS_ST_PUT = 2'b01,
    RBS_ST_WAIT = 2'b11,
    RBS_ST_RUN = 2'b10
  } rbs_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic power_up_timer_enable_n;
    logic brownout_level_select;
    logic external_reset_pin_enable;
    logic osc_start_needed;
  } rbs_cfg_t;

  typedef struct packed {
    logic watchdog;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic stack_reset_enable;
    logic prog_exit;
  } rbs_src_t;

  typedef struct packed {
    rbs_state_t st;
    logic sw_brownout_enable;
    logic brownout_fast_start;
    logic [7:0] rdata;
    logic [15:0] lfo_cnt;
    logic lfo_tick;
    logic [11:0] put_cnt;
    logic [3:0] start_cnt;
    logic [7:0] filt_cnt;
    logic brownout_reset;
    logic core_reset;
    logic bor_active;
    logic bandgap_on;
    logic trip_high;
    logic in_sleep_q;
    logic wake_hold;
  } rbs_regs_t;

endpackage

// File: src/rbs_sequencer.sv
// reset and brown-out sequencer: combines reset causes, power-up timer, brown-out modes
// assumes analog comparators and the oscillator start-up timer are synchronous to mclk
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps

// Contract
// - nine reset causes each hold core reset
// - core held while power-on detector low
// - power-up timer nominal 64 ms holds core
// - timer enabled when active-low bit cleared
// - timer starts after power-on, brown-out release
// - four brown-out modes from two-bit field
// - one bit selects high or low trip
// - brown-out only after filter duration exceeded
// - mode 11 waits ready, active in sleep
// - always-on mode adds no wake delay
// - mode 10 off in sleep, waits ready
// - mode 01 software bit, no start wait
// - software mode protects once ready, sleep-neutral
// - disabled brown-out starts execution immediately
// - forced-on mode sets ready before execution
// - software enable bit 7, resets one
// - fast-start bit 6, resets zero
// - ready flag read-only at bit 0
// - bits 5 to 1 read zero
// - low-power request ORed into brown-out
// - start waits timer, oscillator, pin release
// - ten cycles after pin release if timers done
module rbs_sequencer
  import rbs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire rbs_cfg_t cfg,
  input wire rbs_src_t src,
  input wire logic por_ok,
  input wire logic vdd_below_high,
  input wire logic vdd_below_low,
  input wire logic bor_circuit_ready,
  input wire logic lp_undervoltage_req,
  input wire logic osc_start_done,
  input wire logic external_reset_pin_n,
  input wire logic sleep_req,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic core_reset,
  output logic brownout_reset,
  output logic bor_active,
  output logic bandgap_on,
  output logic trip_high,
  output logic wake_hold
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  rbs_regs_t r;
  rbs_regs_t n;
  logic ext_active;
  logic warm_cause;
  logic bor_want;
  logic bor_ready_eff;
  logic start_gate;
  logic undervolt;
  logic wake_wait;

  // full brown-out control register read value
  function automatic logic [7:0] ctrl_word(input logic sw, input logic fs, input logic rdy);
    ctrl_word = 8'h00;
    ctrl_word[RBS_SW_EN_BIT] = sw;
    ctrl_word[RBS_FAST_START_BIT] = fs;
    ctrl_word[RBS_READY_BIT] = rdy;
  endfunction

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    n = r;
    n.lfo_tick = 1'b0;
    // pin reset only counts when enabled
    ext_active = cfg.external_reset_pin_enable && !external_reset_pin_n;
    warm_cause = src.watchdog || src.reset_instr || src.prog_exit ||
                 (src.stack_reset_enable && (src.stack_over || src.stack_under));
    // circuit enable per mode
    case (cfg.mode)
      RBS_MODE_ON: bor_want = 1'b1;
      RBS_MODE_NOSLEEP: bor_want = !sleep_req;
      RBS_MODE_SW: bor_want = r.sw_brownout_enable;
      default: bor_want = 1'b0;
    endcase
    n.bor_active = bor_want && bor_circuit_ready;
    // forced-on modes report ready at once, ahead of execution
    bor_ready_eff = n.bor_active;
    // band gap on while the circuit is wanted; fast start keeps it alive in the two switchable modes only
    n.bandgap_on = bor_want || ((cfg.mode == RBS_MODE_NOSLEEP || cfg.mode == RBS_MODE_SW) &&
                                r.brownout_fast_start);
    n.trip_high = !cfg.brownout_level_select;
    undervolt = n.trip_high ? vdd_below_high : vdd_below_low;
    // noise filter on the under-voltage comparator
    if (r.bor_active && undervolt) begin
      if (r.filt_cnt != 8'(RBS_FILTER_CYC)) begin
        n.filt_cnt = r.filt_cnt + 8'h01;
      end
    end else begin
      n.filt_cnt = 8'h00;
    end
    n.brownout_reset = (r.bor_active && undervolt && r.filt_cnt == 8'(RBS_FILTER_CYC)) ||
                       lp_undervoltage_req;
    // start-up must wait for ready in forced-on modes, not in software or off modes
    start_gate = (cfg.mode == RBS_MODE_ON || cfg.mode == RBS_MODE_NOSLEEP) ?
                 (bor_ready_eff && !undervolt) : 1'b1;
    // wake from sleep delayed only in mode 10, held until the circuit is ready
    wake_wait = (cfg.mode == RBS_MODE_NOSLEEP) && r.in_sleep_q && !sleep_req &&
                !bor_ready_eff;
    // sleep marker stays set through a pending wake so the hold lasts past one cycle
    n.in_sleep_q = sleep_req ||
                   (r.in_sleep_q && (cfg.mode == RBS_MODE_NOSLEEP) && !bor_ready_eff);
    // low-frequency tick divider
    if (r.lfo_cnt == 16'(RBS_LFO_DIV - 1)) begin
      n.lfo_cnt = 16'h0000;
      n.lfo_tick = 1'b1;
    end else begin
      n.lfo_cnt = r.lfo_cnt + 16'h0001;
    end
    // start-up sequencer
    case (r.st)
      RBS_ST_HOLD: begin
        n.put_cnt = 12'h000;
        if (por_ok && !n.brownout_reset) begin
          n.st = cfg.power_up_timer_enable_n ? RBS_ST_WAIT : RBS_ST_PUT;
        end
      end
      RBS_ST_PUT: begin
        if (r.lfo_tick) begin
          n.put_cnt = r.put_cnt + 12'h001;
        end
        if (r.put_cnt == 12'(RBS_PUT_TICKS)) begin
          n.st = RBS_ST_WAIT;
        end
      end
      RBS_ST_WAIT: begin
        // timers run regardless of the pin; count ten cycles once it is released
        if (ext_active || warm_cause || (cfg.osc_start_needed && !osc_start_done) ||
            !start_gate) begin
          n.start_cnt = 4'h0;
        end else if (r.start_cnt == 4'(RBS_START_CYC - 1)) begin
          n.st = RBS_ST_RUN;
        end else begin
          n.start_cnt = r.start_cnt + 4'h1;
        end
      end
      default: begin
        if (ext_active || warm_cause) begin
          n.st = RBS_ST_WAIT;
          n.start_cnt = 4'h0;
        end
      end
    endcase
    // power-on loss or brown-out restarts the whole sequence
    if (!por_ok || n.brownout_reset) begin
      n.st = RBS_ST_HOLD;
      n.start_cnt = 4'h0;
    end
    n.core_reset = (n.st != RBS_ST_RUN) || wake_wait;
    // wake hold flag registered so the pin comes straight from a flop
    n.wake_hold = wake_wait && (n.st == RBS_ST_RUN);
    // register port
    if (wr_en && addr == RBS_BROWNOUT_CONTROL_ADDR) begin
      n.sw_brownout_enable = wdata[RBS_SW_EN_BIT];
      n.brownout_fast_start = wdata[RBS_FAST_START_BIT];
    end
    if (rd_en && addr == RBS_BROWNOUT_CONTROL_ADDR) begin
      n.rdata = ctrl_word(r.sw_brownout_enable, r.brownout_fast_start, r.bor_active);
    end else begin
      n.rdata = 8'h00;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r.st <= RBS_ST_HOLD;
      r.sw_brownout_enable <= RBS_SW_EN_RST;
      r.brownout_fast_start <= RBS_FAST_START_RST;
      r.rdata <= 8'h00;
      r.lfo_cnt <= 16'h0000;
      r.lfo_tick <= 1'b0;
      r.put_cnt <= 12'h000;
      r.start_cnt <= 4'h0;
      r.filt_cnt <= 8'h00;
      r.brownout_reset <= 1'b0;
      r.core_reset <= 1'b1;
      r.bor_active <= 1'b0;
      r.bandgap_on <= 1'b0;
      r.trip_high <= 1'b0;
      r.in_sleep_q <= 1'b0;
      r.wake_hold <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flip-flops
  assign rdata = r.rdata;
  assign core_reset = r.core_reset;
  assign brownout_reset = r.brownout_reset;
  assign bor_active = r.bor_active;
  assign bandgap_on = r.bandgap_on;
  assign trip_high = r.trip_high;
  assign wake_hold = r.wake_hold;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  por_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !por_ok |=> r.core_reset) else $error("core ran without power-on ok");

  run_needs_put_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(r.st == RBS_ST_WAIT) && $past(r.st) == RBS_ST_PUT |->
    $past(r.put_cnt) == 12'(RBS_PUT_TICKS)) else $error("power-up timer cut short");

  put_bypass_a: assert property (@(posedge mclk) disable iff (!nrst)
    r.st == RBS_ST_HOLD && por_ok && !n.brownout_reset && cfg.power_up_timer_enable_n
    |=> r.st == RBS_ST_WAIT) else $error("timer not bypassed");

  filter_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(r.brownout_reset) && !$past(lp_undervoltage_req) |->
    $past(r.filt_cnt) == 8'(RBS_FILTER_CYC)) else $error("brown-out before filter");

  lp_or_a: assert property (@(posedge mclk) disable iff (!nrst)
    lp_undervoltage_req |=> r.brownout_reset) else $error("low-power request lost");

  pin_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    cfg.external_reset_pin_enable && !external_reset_pin_n |=> r.core_reset)
    else $error("core ran with pin low");

  start_delay_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(r.st == RBS_ST_RUN) |-> $past(r.start_cnt) == 4'(RBS_START_CYC - 1))
    else $error("start delay wrong");

  off_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
    cfg.mode == RBS_MODE_OFF |=> !r.bor_active) else $error("brown-out on in off mode");

  rsvd_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    r.rdata[5:1] == 5'h00) else $error("reserved bits nonzero");

  sleep_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    cfg.mode == RBS_MODE_NOSLEEP && sleep_req |=> !r.bor_active)
    else $error("brown-out active in sleep");

  // a warm cause keeps the core held while it stands
  warm_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    warm_cause |=> r.core_reset) else $error("core ran with warm cause");

  // hold state always keeps the core in reset
  hold_core_a: assert property (@(posedge mclk) disable iff (!nrst)
    r.st == RBS_ST_HOLD |-> r.core_reset) else $error("core free in hold");

  // trip point follows the level select bit
  trip_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
    nrst |=> r.trip_high != $past(cfg.brownout_level_select))
    else $error("trip point wrong");

  // filter restarts whenever the supply is good
  filt_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    !undervolt |=> r.filt_cnt == 8'h00) else $error("filter not cleared");

  // always-on mode is active once the circuit is ready
  on_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
    cfg.mode == RBS_MODE_ON && bor_circuit_ready |=> r.bor_active)
    else $error("always-on not active");

  // always-on mode never holds a wake
  on_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
    cfg.mode == RBS_MODE_ON |=> !r.wake_hold) else $error("wake held in mode 11");

  // software mode follows the enable bit and readiness
  sw_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
    cfg.mode == RBS_MODE_SW |=>
    r.bor_active == ($past(r.sw_brownout_enable) && $past(bor_circuit_ready)))
    else $error("software mode wrong");

  // not ready means not active in every mode
  ready_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    !bor_circuit_ready |=> !r.bor_active) else $error("active before ready");

  // software enable bit takes the written value
  sw_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    wr_en && addr == RBS_BROWNOUT_CONTROL_ADDR |=>
    r.sw_brownout_enable == $past(wdata[RBS_SW_EN_BIT])) else $error("enable write lost");

  // fast-start bit takes the written value
  fs_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    wr_en && addr == RBS_BROWNOUT_CONTROL_ADDR |=>
    r.brownout_fast_start == $past(wdata[RBS_FAST_START_BIT]))
    else $error("fast-start write lost");

  // fast start keeps the band gap up in the switchable modes
  bandgap_fs_a: assert property (@(posedge mclk) disable iff (!nrst)
    (cfg.mode == RBS_MODE_NOSLEEP || cfg.mode == RBS_MODE_SW) && r.brownout_fast_start
    |=> r.bandgap_on) else $error("band gap dropped");

  // read data carries the ready flag at bit 0
  ready_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    rd_en && addr == RBS_BROWNOUT_CONTROL_ADDR |=>
    r.rdata[RBS_READY_BIT] == $past(r.bor_active)) else $error("ready flag misread");

  // read data is zero outside the answer cycle
  rd_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    !rd_en |=> r.rdata == 8'h00) else $error("read data not cleared");

endmodule

// File: test/tb.sv
// testbench for the reset and brown-out sequencer: register port, causes, filter, modes
// assumes the sequencer of src/ with the power-up timer bypassed by configuration
`timescale 1ns/100ps
module tb;
  import rbs_pkg::*;
  logic mclk, nrst, por_ok, vb_hi, vb_lo, rdy, lp_req, osc_done, pin_n, slp;
  logic wr_en, rd_en, rd_seen, r;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic core_reset, brownout_reset, bor_active, bandgap_on, trip_high, wake_hold;
  rbs_cfg_t cfg;
  rbs_src_t src;
  logic [7:0] exp_q[$];
  logic [5:0] causes[5] = '{6'h20, 6'h10, 6'h0A, 6'h06, 6'h01};
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h3a46;
  int i;

  rbs_sequencer DUT (.mclk(mclk), .nrst(nrst), .cfg(cfg), .src(src), .por_ok(por_ok),
    .vdd_below_high(vb_hi), .vdd_below_low(vb_lo), .bor_circuit_ready(rdy),
    .lp_undervoltage_req(lp_req), .osc_start_done(osc_done), .external_reset_pin_n(pin_n),
    .sleep_req(slp), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .core_reset(core_reset), .brownout_reset(brownout_reset),
    .bor_active(bor_active), .bandgap_on(bandgap_on), .trip_high(trip_high),
    .wake_hold(wake_hold));

  // ----------------------------------------
  // clock, hang guard, compare and verdict
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done = checks_done + 1;
    if (seen !== want) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // cycle ceiling and read data watcher, one cycle after each read strobe
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= rd_en;
  end

  // one strobe cycle; reads note their expected byte
  task automatic op(input logic w, input logic [3:0] a, input logic [7:0] dd,
                    input logic [7:0] e);
    @(posedge mclk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= dd;
    if (!w) exp_q.push_back(e);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    por_ok = 1'b1;
    vb_hi = 1'b0;
    vb_lo = 1'b0;
    rdy = 1'b1;
    lp_req = 1'b0;
    osc_done = 1'b1;
    pin_n = 1'b1;
    slp = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    rd_seen = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    src = '0;
    cfg = '{RBS_MODE_OFF, 1'b1, 1'b0, 1'b1, 1'b1};
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    idle(30);
    chk(core_reset, 1'b0);
    // reset value, read-only and zero bits, unmapped address, random bytes
    op(0, 4'h0, 8'h00, 8'h80);
    op(1, 4'h0, 8'hFF, 8'h00);
    op(0, 4'h0, 8'h00, 8'hC0);
    op(1, 4'h5, 8'h00, 8'h00);
    op(0, 4'h5, 8'h00, 8'h00);
    op(0, 4'h0, 8'h00, 8'hC0);
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      op(1, 4'h0, d, 8'h00);
      op(0, 4'h0, 8'h00, {d[7:6], 6'h00});
    end
    // every mode with software enable low and high
    for (i = 0; i < 8; i++) begin
      idle(1);
      cfg.mode <= i[2:1];
      cfg.brownout_level_select <= i[0];
      op(1, 4'h0, {i[0], 7'h40}, 8'h00);
      idle(4);
      r = i[2] | (i[2:1] == 2'h1 && i[0]);
      chk(trip_high, !i[0]);
      chk(bor_active, r);
      if (i[2:1] == 2'h1 && !i[0]) chk(bandgap_on, 1'b1);
      op(0, 4'h0, 8'h00, {i[0], 1'b1, 5'h00, r});
      idle(2);
    end
    cfg.brownout_level_select <= 1'b0;
    src <= 6'h08;
    idle(4);
    chk(core_reset, 1'b0);
    for (i = 0; i < 5; i++) begin
      src <= causes[i];
      idle(4);
      chk(core_reset, 1'b1);
      src <= '0;
      idle(5);
      chk(core_reset, 1'b1);
      idle(20);
      chk(core_reset, 1'b0);
    end
    // pin held low, then ten cycles to run
    pin_n <= 1'b0;
    idle(30);
    chk(core_reset, 1'b1);
    pin_n <= 1'b1;
    idle(8);
    chk(core_reset, 1'b1);
    idle(10);
    chk(core_reset, 1'b0);
    // short dip ignored, long dip resets
    vb_hi <= 1'b1;
    idle(200);
    vb_hi <= 1'b0;
    idle(2);
    chk(brownout_reset, 1'b0);
    chk(core_reset, 1'b0);
    vb_hi <= 1'b1;
    idle(300);
    chk(brownout_reset, 1'b1);
    chk(core_reset, 1'b1);
    vb_hi <= 1'b0;
    idle(40);
    chk(core_reset, 1'b0);
    lp_req <= 1'b1;
    idle(4);
    chk(brownout_reset, 1'b1);
    lp_req <= 1'b0;
    idle(40);
    por_ok <= 1'b0;
    idle(4);
    chk(core_reset, 1'b1);
    por_ok <= 1'b1;
    idle(40);
    chk(core_reset, 1'b0);
    // wake from sleep: mode 10 waits for ready, always-on does not
    cfg.mode <= RBS_MODE_NOSLEEP;
    slp <= 1'b1;
    idle(4);
    chk(bor_active, 1'b0);
    rdy <= 1'b0;
    slp <= 1'b0;
    idle(4);
    chk(wake_hold, 1'b1);
    rdy <= 1'b1;
    idle(4);
    chk(wake_hold, 1'b0);
    cfg.mode <= RBS_MODE_ON;
    slp <= 1'b1;
    idle(4);
    rdy <= 1'b0;
    slp <= 1'b0;
    idle(4);
    chk(wake_hold, 1'b0);
    idle(3);
    final_report();
  end
endmodule
